// *** shared/wdt_params.svh ***
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
// Overview of operation
// - start in long open window; first trigger ends it
// - toggle trigger in safe area; restarts cycle
// - eighth consecutive failure: main regulator off briefly
// - seven more failures: forced battery standby, flag
// - unserved after wake: forced standby again, counter saturates
// - failure: outputs off, flag, reset pulse, fail-safe
// - period field writable only right after unlock
// - active mode: four fail-safe entry events
// - regulator standby: fail-safe entry events, watchdog conditional
// - fail-safe: pulldowns on, control words cleared to zero unless forced standby loads defaults, pump off
// - fail-safe blocks writes except listed fields
// - link transmitter stays on unless hot cluster
// - leave fail-safe when cause gone and read
// - failure increments counter; recovery trigger then read
// - undervoltage flags; exit above threshold after read
// - forced standby: power-on defaults except dither bit
// - forced standby on watchdog, heat, or short
// - reset release restarts long open window
// =========================================================
// timing
`define WD_CLK_NS 40
`define WD_TICK_NS 1000000
`define WD_TICK_CYC ((`WD_TICK_NS + `WD_CLK_NS - 1) / `WD_CLK_NS)
`define WD_LW_MS 8'd200
`define WD_OFF_MS 8'd200
`define WD_RST_MS 8'd2
`define WD_FAIL_OFF 4'd8
`define WD_FAIL_MAX 4'd15
`define HEAT_MAX 3'd7
// =========================================================
// register offsets
`define A_CW1 4'h0
`define A_CW2 4'h1
`define A_CFG 4'h2
`define A_HS 4'h3
`define A_PWMF 4'h4
`define A_PWMD 4'h5
`define A_SW1 4'h8
`define A_SW2 4'h9
`define A_IST 4'ha
`define A_IMSK 4'hb
// =========================================================
// fields, defaults, fail-safe write masks
`define WATCHDOG_TRIGGER_BIT_BIT 0
`define UNLOCK_BIT 1
`define DITH_BIT 5
`define CW1_RSB_BIT 1
`define CW1_BSB_BIT 2
`define CW1_V2_BIT 4
`define CW1_PWR_BIT 8
`define POR_CW2 32'h0000_0003
`define FSM_CW1 32'h0000_0031
`define FSM_CW2 32'h00ff_ff00
`define FSM_CFG 32'h0000_0001
`define FSM_HS 32'h0000_00ff
`define FSM_ALL 32'hffff_ffff
`define PER_MASK 32'h0000_0003
`endif

// *** shared/wdt_pkg.sv ***
package wdt_pkg;
  typedef enum logic [3:0] {
    M_ACT = 4'b0001,
    M_RSB = 4'b0010,
    M_BSB = 4'b0100,
    M_FSB = 4'b1000
  } mode_t;
  typedef enum logic [4:0] {
    W_IDLE = 5'b00001,
    W_LONG = 5'b00010,
    W_WIN = 5'b00100,
    W_RST = 5'b01000,
    W_OFF = 5'b10000
  } wd_t;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_PER = 4'b0010,
    H_CAP = 4'b0100,
    H_GAP = 4'b1000
  } hst_t;
endpackage

// *** shared/ctrl_link_if.sv ***
`timescale 1ns/100ps
interface ctrl_link_if;
  logic wr;
  logic rd;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic rst_o;
  logic rst_oe;
  logic reset_line;
  // open drain with pull-up
  assign reset_line = rst_oe ? rst_o : 1'b1;
  modport device (input wr, rd, addr, wdata, output rdata, rst_o, rst_oe);
  modport host (output wr, rd, addr, wdata, input rdata, reset_line);
endinterface

// *** design/wdt_device.sv ***
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`include "wdt_params.svh"
module wdt_device #(
  parameter int TICK_CYCLES = `WD_TICK_CYC
) (
  input wire logic clock, // 25 MHz
  input wire logic reset, // async, high
  ctrl_link_if.device link, // command port
  input wire logic mr_uv_in, // main regulator under threshold, filtered
  input wire logic mr_short_in, // main regulator short at turn-on
  input wire logic thermal_shutdown_first_level_hot_in, // first-level shutdown in cluster 5/6
  input wire logic thermal_shutdown_second_level_in, // second-level shutdown
  input wire logic load_high_in, // load current over comparator
  input wire logic wake_in, // any wake-up source
  output logic main_reg_en, // main regulator on
  output logic sec_reg_en, // secondary regulator on
  output logic power_out_en, // power outputs allowed
  output logic pulldown_a, // fail-safe pulldown a
  output logic pulldown_b, // fail-safe pulldown b
  output logic pump_en, // charge pump on
  output logic lin_tx_en, // link transmitter on
  output logic irq // level interrupt
);
  // =========================================================
  // constants and helpers
  localparam logic [31:0] POR_VAL [6] = '{32'h0, `POR_CW2, 32'h0, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] FSM_VAL [6] = '{`FSM_CW1, `FSM_CW2, `FSM_CFG, `FSM_HS, `FSM_ALL,
                                          `FSM_ALL};

  function automatic logic [7:0] period_ms(input logic [1:0] sel);
    case (sel)
      2'h0: period_ms = 8'd10;
      2'h1: period_ms = 8'd20;
      2'h2: period_ms = 8'd50;
      default: period_ms = 8'd100;
    endcase
  endfunction

  function automatic logic [31:0] wmask(input int idx, input logic fs, input logic unl);
    logic [31:0] m;
    m = fs ? FSM_VAL[idx] : 32'hffff_ffff;
    if (idx == 0 || idx == 2) begin
      m[`WATCHDOG_TRIGGER_BIT_BIT] = 1'b0;
    end
    if (idx == 2) begin
      m[`UNLOCK_BIT] = 1'b0;
    end
    if (idx == 1) begin
      m = unl ? (m | `PER_MASK) : (m & ~`PER_MASK);
    end
    wmask = m;
  endfunction

  // =========================================================
  // state
  logic [15:0] div_ff;
  logic tick_ff;
  logic [31:0] ctrl_ff [6];
  logic watchdog_trigger_bit_ff, unlock_ff, fs_ff, fs_read_ff, wd_cause_ff, thermal_shutdown_second_level_d_ff;
  logic [3:0] fail_cnt_ff;
  logic [2:0] heat_cnt_ff;
  logic [7:0] wd_cnt_ff;
  logic [5:0] sr1_ff;
  logic [2:0] ist_ff, msk_ff;
  logic [31:0] rdata_ff;
  wdt_pkg::mode_t mode_ff, nxt_mode;
  wdt_pkg::wd_t wd_ff, nxt_wd;
  logic rst_oe_ff, main_ff, sec_ff, pwr_ff, pd_ff, pump_ff, lin_ff, irq_ff;

  // =========================================================
  // decode
  wire cmd = link.wr | link.rd;
  wire watchdog_trigger_bit_wr = link.wr && (link.addr == `A_CW1 || link.addr == `A_CFG);
  wire watchdog_trigger_bit_val = link.wdata[`WATCHDOG_TRIGGER_BIT_BIT];
  wire watchdog_trigger_bit_toggle = watchdog_trigger_bit_wr && (watchdog_trigger_bit_val != watchdog_trigger_bit_ff);
  wire rd_sr1 = link.rd && link.addr == `A_SW1;
  wire rd_ist = link.rd && link.addr == `A_IST;
  wire is_act = mode_ff == wdt_pkg::M_ACT;
  wire is_rsb = mode_ff == wdt_pkg::M_RSB;
  wire is_off_mode = mode_ff == wdt_pkg::M_BSB || mode_ff == wdt_pkg::M_FSB;
  wire wd_run = is_act || (is_rsb && load_high_in);
  wire in_long = wd_ff == wdt_pkg::W_LONG;
  wire in_win = wd_ff == wdt_pkg::W_WIN;
  wire [7:0] period = period_ms(ctrl_ff[1][1:0]);
  wire open_area = wd_cnt_ff >= (period >> 1);
  // =========================================================
  // watchdog events
  wire good_long = wd_run && in_long && watchdog_trigger_bit_wr && watchdog_trigger_bit_val;
  wire good_win = wd_run && in_win && watchdog_trigger_bit_toggle && open_area;
  wire early = wd_run && in_win && watchdog_trigger_bit_toggle && !open_area;
  wire expire = wd_run && tick_ff && ((in_long && wd_cnt_ff == `WD_LW_MS - 8'd1) ||
                (in_win && wd_cnt_ff == period - 8'd1));
  wire wd_fail = early || expire;
  wire [3:0] fail_nc = (fail_cnt_ff == `WD_FAIL_MAX) ? `WD_FAIL_MAX
                       : fail_cnt_ff + 4'd1;
  wire go_off = wd_fail && fail_nc == `WD_FAIL_OFF;
  wire go_forced_wd = wd_fail && fail_nc == `WD_FAIL_MAX;
  wire thermal_shutdown_second_level_rise = thermal_shutdown_second_level_in && !thermal_shutdown_second_level_d_ff && (is_act || is_rsb);
  wire heat_max = thermal_shutdown_second_level_rise && heat_cnt_ff == `HEAT_MAX - 3'd1;
  wire short_ev = mr_short_in && is_act;
  wire go_forced = go_forced_wd || heat_max || short_ev;
  wire wake = wake_in && !is_act && !is_rsb ? 1'b1 : (wake_in && is_rsb);
  // =========================================================
  // fail-safe
  wire fs_set = wd_fail || (is_act && (short_ev || mr_uv_in || thermal_shutdown_second_level_in)) ||
                (is_rsb && (mr_uv_in || thermal_shutdown_second_level_in));
  wire cause_live = mr_uv_in || thermal_shutdown_second_level_in || wd_cause_ff ||
                    mode_ff == wdt_pkg::M_FSB;
  wire fs_clear = fs_ff && fs_read_ff && !cause_live && !fs_set;
  wire fs_entry = (fs_set || go_forced) && !fs_ff;
  wire nxt_fs = fs_set || go_forced || (fs_ff && !fs_clear);

  always_comb begin
    nxt_mode = mode_ff;
    if (go_forced) begin
      nxt_mode = wdt_pkg::M_FSB;
    end else if (wake) begin
      nxt_mode = wdt_pkg::M_ACT;
    end else if (is_act && link.wr && link.addr == `A_CW1) begin
      if (link.wdata[`CW1_RSB_BIT]) begin
        nxt_mode = wdt_pkg::M_RSB;
      end else if (link.wdata[`CW1_BSB_BIT]) begin
        nxt_mode = wdt_pkg::M_BSB;
      end
    end
  end

  always_comb begin
    nxt_wd = wd_ff;
    case (wd_ff)
      wdt_pkg::W_IDLE, wdt_pkg::W_LONG, wdt_pkg::W_WIN, wdt_pkg::W_RST,
      wdt_pkg::W_OFF: begin
        if (go_forced) begin
          nxt_wd = wdt_pkg::W_IDLE;
        end else if (wd_fail) begin
          nxt_wd = go_off ? wdt_pkg::W_OFF : wdt_pkg::W_RST;
        end else if (wake && is_off_mode) begin
          nxt_wd = wdt_pkg::W_RST; // regulator turn-on pulses reset
        end else if (wake) begin
          nxt_wd = wdt_pkg::W_LONG;
        end else if (nxt_mode == wdt_pkg::M_BSB) begin
          nxt_wd = wdt_pkg::W_IDLE;
        end else if (wd_ff == wdt_pkg::W_RST && tick_ff && wd_cnt_ff == `WD_RST_MS - 8'd1) begin
          nxt_wd = wdt_pkg::W_LONG;
        end else if (wd_ff == wdt_pkg::W_OFF && tick_ff && wd_cnt_ff == `WD_OFF_MS - 8'd1) begin
          nxt_wd = wdt_pkg::W_RST;
        end else if (good_long || good_win) begin
          nxt_wd = wdt_pkg::W_WIN;
        end
      end
      default: nxt_wd = wdt_pkg::W_RST;
    endcase
  end

  wire restart = nxt_wd != wd_ff || good_win;
  wire timed = wd_ff == wdt_pkg::W_RST || wd_ff == wdt_pkg::W_OFF || wd_run;
  wire [7:0] nxt_wd_cnt = restart ? 8'd0 : (tick_ff && timed) ? wd_cnt_ff + 8'd1 : wd_cnt_ff;
  wire [5:0] sr1_set = {heat_max || short_ev, go_forced_wd, thermal_shutdown_second_level_in,
                        thermal_shutdown_first_level_hot_in || thermal_shutdown_second_level_in, mr_uv_in, wd_fail};
  wire [2:0] ist_set = {go_forced && mode_ff != wdt_pkg::M_FSB, fs_entry, wd_fail};
  wire [31:0] sr1_rd = {20'h0, fail_cnt_ff, 2'b0, sr1_ff};
  wire [31:0] sr2_rd = {19'h0, wd_ff, 2'b0, mode_ff, 1'b0, fs_ff};
  wire [31:0] ctrl_rd = (link.addr == `A_CW1 || link.addr == `A_CFG) ?
                        {ctrl_ff[link.addr[2:0]][31:1], watchdog_trigger_bit_ff} : ctrl_ff[link.addr[2:0]];
  wire [31:0] nxt_rdata = !link.rd ? 32'h0 :
                          (link.addr < 4'h6) ? ctrl_rd :
                          (link.addr == `A_SW1) ? sr1_rd :
                          (link.addr == `A_SW2) ? sr2_rd :
                          (link.addr == `A_IST) ? {29'h0, ist_ff} :
                          (link.addr == `A_IMSK) ? {29'h0, msk_ff} : 32'h0;

  // =========================================================
  // control words
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_ctrl
      wire hit = link.wr && link.addr == 4'(gi);
      wire [31:0] m = wmask(gi, fs_ff, unlock_ff);
      wire [31:0] keep = (gi == 2) ? (32'h1 << `DITH_BIT) : 32'h0;
      wire [31:0] nxt_ctrl = go_forced ? ((POR_VAL[gi] & ~keep) | (ctrl_ff[gi] & keep)) :
                             fs_entry ? 32'h0 :
                             hit ? ((ctrl_ff[gi] & ~m) | (link.wdata & m)) : ctrl_ff[gi];
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          ctrl_ff[gi] <= POR_VAL[gi];
        end else begin
          ctrl_ff[gi] <= nxt_ctrl;
        end
      end
    end
  endgenerate

  // =========================================================
  // registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      div_ff <= 16'h0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= div_ff == 16'(TICK_CYCLES - 1);
      div_ff <= (div_ff == 16'(TICK_CYCLES - 1)) ? 16'h0 : div_ff + 16'h1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_ff <= wdt_pkg::M_ACT;
      wd_ff <= wdt_pkg::W_RST;
      wd_cnt_ff <= 8'h0;
      watchdog_trigger_bit_ff <= 1'b0;
      unlock_ff <= 1'b0;
      fail_cnt_ff <= 4'h0;
      heat_cnt_ff <= 3'h0;
      thermal_shutdown_second_level_d_ff <= 1'b0;
      wd_cause_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      wd_ff <= nxt_wd;
      wd_cnt_ff <= nxt_wd_cnt;
      watchdog_trigger_bit_ff <= (watchdog_trigger_bit_wr && !go_forced) ? watchdog_trigger_bit_val : (go_forced ? 1'b0 : watchdog_trigger_bit_ff);
      unlock_ff <= cmd ? (link.wr && link.addr == `A_CFG && link.wdata[`UNLOCK_BIT] &&
                          !fs_ff) : unlock_ff;
      fail_cnt_ff <= wd_fail ? fail_nc : (good_long ? 4'h0 : fail_cnt_ff);
      heat_cnt_ff <= thermal_shutdown_second_level_rise ? (heat_max ? 3'h0 : heat_cnt_ff + 3'h1) : heat_cnt_ff;
      thermal_shutdown_second_level_d_ff <= thermal_shutdown_second_level_in;
      wd_cause_ff <= wd_fail || (wd_cause_ff && !good_long);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fs_ff <= 1'b0;
      fs_read_ff <= 1'b0;
      sr1_ff <= 6'h0;
      ist_ff <= 3'h0;
      msk_ff <= 3'h0;
      rdata_ff <= 32'h0;
    end else begin
      fs_ff <= nxt_fs;
      fs_read_ff <= (fs_set || go_forced) ? 1'b0 : (fs_read_ff || (rd_sr1 && fs_ff));
      sr1_ff <= (rd_sr1 ? 6'h0 : sr1_ff) | sr1_set; // set wins over read clear
      ist_ff <= (rd_ist ? 3'h0 : ist_ff) | ist_set;
      msk_ff <= (link.wr && link.addr == `A_IMSK) ? link.wdata[2:0] : msk_ff;
      rdata_ff <= nxt_rdata;
    end
  end

  // =========================================================
  // outputs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rst_oe_ff <= 1'b1;
      main_ff <= 1'b1;
      sec_ff <= 1'b0;
      pwr_ff <= 1'b0;
      pd_ff <= 1'b0;
      pump_ff <= 1'b0;
      lin_ff <= 1'b1;
      irq_ff <= 1'b0;
    end else begin
      rst_oe_ff <= wd_ff == wdt_pkg::W_RST || wd_ff == wdt_pkg::W_OFF || is_off_mode;
      main_ff <= wd_ff != wdt_pkg::W_OFF && !is_off_mode;
      sec_ff <= ctrl_ff[0][`CW1_V2_BIT] && !fs_ff;
      pwr_ff <= is_act && !fs_ff && ctrl_ff[0][`CW1_PWR_BIT];
      pd_ff <= fs_ff;
      pump_ff <= is_act && !fs_ff;
      lin_ff <= !thermal_shutdown_first_level_hot_in;
      irq_ff <= |(ist_ff & msk_ff);
    end
  end

  assign link.rst_o = 1'b0;
  assign link.rst_oe = rst_oe_ff;
  assign link.rdata = rdata_ff;
  assign main_reg_en = main_ff;
  assign sec_reg_en = sec_ff;
  assign power_out_en = pwr_ff;
  assign pulldown_a = pd_ff;
  assign pulldown_b = pd_ff;
  assign pump_en = pump_ff;
  assign lin_tx_en = lin_ff;
  assign irq = irq_ff;
endmodule

// *** design/wdt_host.sv ***
`timescale 1ns/100ps
`include "wdt_params.svh"
module wdt_host (
  input wire logic clock, // 25 MHz
  input wire logic reset, // async, high
  ctrl_link_if.host link, // to device
  input wire logic [3:0] addr, // own register address
  input wire logic [31:0] wdata, // own write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata // read data, cycle after rd
);
  // =========================================================
  // own registers: 0 control, 1 service interval, 2 status
  logic [3:0] ctl_ff; // serve, dither, period[1:0]
  logic [15:0] intv_ff;
  logic [15:0] sr1_ff;
  logic cfg_pend_ff, rec_pend_ff, armed_ff, watchdog_trigger_bit_ff, busy_ff;
  logic [15:0] cnt_ff;
  logic [31:0] rdata_ff;
  logic l_wr_ff, l_rd_ff, cap_ff;
  logic [3:0] l_addr_ff;
  logic [31:0] l_wdata_ff;
  wdt_pkg::hst_t st_ff, nxt_st;

  wire own_ctl = wr && addr == 4'h0;
  wire up = link.reset_line;
  wire serve = ctl_ff[0];
  wire [31:0] cfg_word = {26'h0, ctl_ff[1], 4'h0, watchdog_trigger_bit_ff};
  wire due_arm = serve && up && !armed_ff;
  wire due_tog = serve && up && armed_ff && cnt_ff >= intv_ff;
  wire idle = st_ff == wdt_pkg::H_IDLE;
  wire do_unlock = idle && cfg_pend_ff && up;
  wire do_watchdog_trigger_bit = idle && !do_unlock && (due_arm || due_tog);
  wire do_read = idle && !do_unlock && !do_watchdog_trigger_bit && rec_pend_ff && up;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      wdt_pkg::H_IDLE: begin
        if (do_unlock) begin
          nxt_st = wdt_pkg::H_PER;
        end else if (do_read) begin
          nxt_st = wdt_pkg::H_CAP;
        end
      end
      wdt_pkg::H_PER: nxt_st = wdt_pkg::H_GAP;
      wdt_pkg::H_CAP: nxt_st = wdt_pkg::H_IDLE;
      wdt_pkg::H_GAP: nxt_st = wdt_pkg::H_IDLE;
      default: nxt_st = wdt_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_ff <= wdt_pkg::H_IDLE;
      ctl_ff <= 4'h0;
      intv_ff <= 16'hffff;
      cfg_pend_ff <= 1'b0;
      rec_pend_ff <= 1'b0;
      sr1_ff <= 16'h0;
      rdata_ff <= 32'h0;
    end else begin
      st_ff <= nxt_st;
      ctl_ff <= own_ctl ? {wdata[5:4], wdata[3], wdata[0]} : ctl_ff;
      intv_ff <= (wr && addr == 4'h1) ? wdata[15:0] : intv_ff;
      cfg_pend_ff <= (own_ctl && wdata[1]) || (cfg_pend_ff && !do_unlock);
      rec_pend_ff <= (own_ctl && wdata[2]) || (rec_pend_ff && !do_read);
      // device answers one cycle after the strobe, so capture a cycle after it
      sr1_ff <= cap_ff ? link.rdata[15:0] : sr1_ff;
      rdata_ff <= !rd ? 32'h0 : (addr == 4'h0) ? {26'h0, ctl_ff[3:1], 2'b0, ctl_ff[0]} :
                  (addr == 4'h1) ? {16'h0, intv_ff} :
                  (addr == 4'h2) ? {sr1_ff, 13'h0, cfg_pend_ff || rec_pend_ff, busy_ff, up} :
                  32'h0;
    end
  end

  // =========================================================
  // trigger service and strobes
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      armed_ff <= 1'b0;
      watchdog_trigger_bit_ff <= 1'b0;
      cnt_ff <= 16'h0;
      busy_ff <= 1'b0;
      l_wr_ff <= 1'b0;
      l_rd_ff <= 1'b0;
      cap_ff <= 1'b0;
      l_addr_ff <= 4'h0;
      l_wdata_ff <= 32'h0;
    end else begin
      armed_ff <= up && (armed_ff || do_watchdog_trigger_bit);
      watchdog_trigger_bit_ff <= !up ? 1'b0 : (do_watchdog_trigger_bit ? (due_arm ? 1'b1 : !watchdog_trigger_bit_ff) : watchdog_trigger_bit_ff);
      cnt_ff <= (!up || do_watchdog_trigger_bit) ? 16'h0 : (cnt_ff == 16'hffff ? cnt_ff : cnt_ff + 16'h1);
      busy_ff <= !idle || do_unlock || do_read;
      l_wr_ff <= do_unlock || do_watchdog_trigger_bit || st_ff == wdt_pkg::H_PER;
      l_rd_ff <= do_read;
      cap_ff <= l_rd_ff;
      l_addr_ff <= (do_unlock || do_watchdog_trigger_bit) ? `A_CFG : do_read ? `A_SW1 : `A_CW2;
      if (do_unlock) begin
        l_wdata_ff <= cfg_word | (32'h1 << `UNLOCK_BIT);
      end else if (do_watchdog_trigger_bit) begin
        l_wdata_ff <= {26'h0, ctl_ff[1], 4'h0, due_arm ? 1'b1 : !watchdog_trigger_bit_ff};
      end else if (st_ff == wdt_pkg::H_PER) begin
        l_wdata_ff <= {30'h0, ctl_ff[3:2]};
      end else begin
        l_wdata_ff <= 32'h0;
      end
    end
  end

  assign link.wr = l_wr_ff;
  assign link.rd = l_rd_ff;
  assign link.addr = l_addr_ff;
  assign link.wdata = l_wdata_ff;
  assign rdata = rdata_ff;
endmodule

// *** verif/wdt_link_chk.sv ***
`timescale 1ns/100ps
`include "wdt_params.svh"
module wdt_link_chk (
  input wire logic clock, // core clock
  input wire logic reset, // async, high
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [3:0] addr, // register index
  input wire logic [31:0] wdata, // write data
  input wire logic [31:0] rdata, // read data
  input wire logic rst_oe, // reset line pulled low
  input wire logic reset_line // resolved reset line
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // ===========
  // host side of the link
  strobe_excl_a: assert property (!(wr && rd))
    else $error("write and read strobes together");
  unlock_next_a: assert property (
    wr && addr == `A_CFG && wdata[`UNLOCK_BIT] |=> wr && addr == `A_CW2)
    else $error("period write does not follow unlock");
  host_wr_a: assert property (wr |-> addr inside {`A_CW1, `A_CW2, `A_CFG})
    else $error("host writes outside control words");
  host_rd_a: assert property (rd |-> addr == `A_SW1)
    else $error("host reads other than status word one");
  watchdog_trigger_bit_up_a: assert property (wr && addr == `A_CFG |-> reset_line)
    else $error("trigger written while reset line low");
  // ===========
  // device side of the link
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  rst_pulse_a: assert property ($rose(rst_oe) |-> rst_oe [*5])
    else $error("reset pulse too short");
  long_win_a: assert property ($fell(rst_oe) |-> !rst_oe [*8])
    else $error("failure right after reset release");
  cover property ($rose(rst_oe));
  cover property (wr && addr == `A_CFG ##1 wr && addr == `A_CW2);
  cover property (rd ##1 rdata != 32'h0);
endmodule

// *** verif/window_watchdog_failsafe_tb.sv ***
`timescale 1ns/100ps
module window_watchdog_failsafe_tb;
  logic clock, reset, wr, rd, mr_uv_in, mr_short_in, thermal_shutdown_first_level_hot_in, thermal_shutdown_second_level_in, wake_in, irq;
  logic main_reg_en, sec_reg_en, power_out_en, pulldown_a, pulldown_b, pump_en, lin_tx_en;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] s;
  int failures, total_checks, cycles, pulses, base;
  ctrl_link_if link();
  wdt_device #(.TICK_CYCLES(4)) u_wdt_device (.clock(clock), .reset(reset), .link(link),
    .mr_uv_in(mr_uv_in), .mr_short_in(mr_short_in), .thermal_shutdown_first_level_hot_in(thermal_shutdown_first_level_hot_in),
    .thermal_shutdown_second_level_in(thermal_shutdown_second_level_in),
    .load_high_in(1'b0), .wake_in(wake_in), .main_reg_en(main_reg_en),
    .sec_reg_en(sec_reg_en), .power_out_en(power_out_en), .pulldown_a(pulldown_a),
    .pulldown_b(pulldown_b), .pump_en(pump_en), .lin_tx_en(lin_tx_en), .irq(irq));
  wdt_host u_wdt_host (.clock(clock), .reset(reset), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  wdt_link_chk u_wdt_link_chk (.clock(clock), .reset(reset), .wr(link.wr), .rd(link.rd),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .rst_oe(link.rst_oe),
    .reset_line(link.reset_line));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(negedge link.reset_line) pulses++;
  // ===========
  // run ceiling, well above the longest failure chain
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      final_report();
    end
  end
  task automatic final_report();
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: return link.reset_line;
      1: return main_reg_en;
      2: return pulldown_a;
      default: return lin_tx_en;
    endcase
  endfunction
  task automatic wait_on(input int sel, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(sel) !== v && n < lim) begin
      @(negedge clock);
      n++;
    end
    chk($sformatf("signal %0d", sel), {31'h0, v}, {31'h0, pick(sel)});
  endtask
  task automatic hw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic hr(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask
  // recover read, then poll until the captured status word is in
  task automatic recover(input logic [31:0] ctrl);
    logic [31:0] st;
    int n;
    hw(4'h0, ctrl | 32'h4);
    n = 0;
    st = 32'h6;
    while (st[2:1] !== 2'b00 && n < 50) begin
      hr(4'h2, st);
      n++;
    end
    s = st[31:16];
  endtask
  task automatic wake();
    @(posedge clock);
    wake_in <= 1'b1;
    @(posedge clock);
    wake_in <= 1'b0;
  endtask
  // ===========
  // main sequence
  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    mr_uv_in = 1'b0;
    mr_short_in = 1'b0;
    thermal_shutdown_first_level_hot_in = 1'b0;
    thermal_shutdown_second_level_in = 1'b0;
    wake_in = 1'b0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    wait_on(0, 1'b1, 50);
    chk("irq", 32'h0, {31'h0, irq});
    // causes tried inside the first long window, before any serving
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      mr_uv_in <= (i == 0);
      thermal_shutdown_second_level_in <= (i == 1);
      wait_on(2, 1'b1, 20);
      recover(32'h0);
      chk("cause flag", 32'h1, {31'h0, s[i * 2 + 1]});
      chk("fs held", 32'h1, {31'h0, pulldown_a});
      @(posedge clock);
      mr_uv_in <= 1'b0;
      thermal_shutdown_second_level_in <= 1'b0;
      recover(32'h0);
      wait_on(2, 1'b0, 20);
    end
    @(posedge clock);
    thermal_shutdown_first_level_hot_in <= 1'b1;
    wait_on(3, 1'b0, 10);
    @(posedge clock);
    thermal_shutdown_first_level_hot_in <= 1'b0;
    // 60-cycle toggles only fit once the 20 ms period lands
    hw(4'h1, 32'h3c);
    hw(4'h0, 32'h13);
    base = pulses;
    repeat (1500) @(negedge clock);
    chk("reset pulses", base, pulses);
    recover(32'h11);
    chk("fail count", 32'h0, {28'h0, s[11:8]});
    // toggles in the closed half
    hw(4'h1, 32'ha);
    wait_on(0, 1'b0, 300);
    chk("pulldowns", 32'h3, {30'h0, pulldown_a, pulldown_b});
    chk("outputs off", 32'h0, {29'h0, pump_en, power_out_en, sec_reg_en});
    chk("link tx", 32'h1, {31'h0, lin_tx_en});
    // serving stops while reset is still low, so the host cannot arm again
    recover(32'h10);
    chk("fail flag", 32'h1, {31'h0, s[0]});
    chk("fail count", 32'h1, {28'h0, s[11:8]});
    wait_on(1, 1'b0, 8000);
    wait_on(1, 1'b1, 1000);
    wait_on(1, 1'b0, 8000);
    repeat (1200) @(negedge clock);
    chk("main off", 32'h0, {31'h0, main_reg_en});
    // host is unpowered in forced standby; status bits stay sticky
    wake();
    wait_on(1, 1'b1, 50);
    recover(32'h10);
    chk("forced by wd", 32'h1, {31'h0, s[4]});
    chk("fail count", 32'hf, {28'h0, s[11:8]});
    wait_on(1, 1'b0, 1200);
    // period back at its power-on default of 100 ms
    hw(4'h1, 32'h12c);
    wake();
    wait_on(1, 1'b1, 50);
    recover(32'h10);
    chk("fail flag", 32'h1, {31'h0, s[0]});
    chk("fail count", 32'hf, {28'h0, s[11:8]});
    hw(4'h0, 32'h1);
    repeat (1600) @(negedge clock);
    recover(32'h1);
    chk("fail count", 32'h0, {28'h0, s[11:8]});
    wait_on(2, 1'b0, 20);
    @(posedge clock);
    mr_short_in <= 1'b1;
    wait_on(1, 1'b0, 10);
    chk("short fs", 32'h1, {31'h0, pulldown_a});
    final_report();
  end
endmodule
